// ### rtl/rfs_pkg.sv
package rfs_pkg;

  // ----------------------------------------------------------------
  // widths and units (frequency in 0.01 Hz steps)
  // ----------------------------------------------------------------
  localparam int          FREQ_W       = 16;
  localparam int          TIME_W       = 16;
  localparam logic [1:0]  SEL_MULTI    = 2'h0;
  localparam logic [1:0]  SEL_STORE    = 2'h1;
  localparam logic [1:0]  SEL_NOSTORE  = 2'h2;
  localparam logic [1:0]  SEL_STOPCLR  = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint      CLK_HZ       = 40_000_000;
  localparam longint      MINUTE_S     = 60;
  localparam longint      MINUTE_CYC   = MINUTE_S * CLK_HZ;
  localparam longint      RAMP_REF_HZ  = 60;
  localparam longint      RAMP_STEPS   = RAMP_REF_HZ * 100;
  localparam longint      RAMP_TIME_S  = 5;
  // cycles per 0.01 Hz step for a 5 s ramp to the reference frequency
  localparam logic [15:0] RAMP_PER_RST = 16'(RAMP_TIME_S * CLK_HZ / RAMP_STEPS);
  localparam logic [15:0] DECEL_SAME   = 16'h270f;

  // ----------------------------------------------------------------
  // register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_MAXF     = 8'h04;
  localparam logic [7:0]  OFS_PANEL    = 8'h08;
  localparam logic [7:0]  OFS_PRIM     = 8'h0c;
  localparam logic [7:0]  OFS_SEC      = 8'h10;
  localparam logic [7:0]  OFS_STAT     = 8'h14;
  localparam logic [7:0]  OFS_CMD      = 8'h18;
  localparam logic [15:0] MAXF_RST     = 16'h2ee0;
  localparam logic [15:0] PANEL_RST    = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       comp;
    logic [1:0] sel;
  } rfs_ctrl_t;

  typedef struct packed {
    logic [15:0] decel;
    logic [15:0] accel;
  } rfs_ramp_t;

  localparam rfs_ctrl_t CTRL_RST = '{comp: 1'b0, sel: SEL_MULTI};
  localparam rfs_ramp_t PRIM_RST = '{decel: RAMP_PER_RST, accel: RAMP_PER_RST};
  localparam rfs_ramp_t SEC_RST  = '{decel: DECEL_SAME, accel: RAMP_PER_RST};

endpackage

// ### rtl/rfs_tick.sv
`timescale 1ns/10ps
module rfs_tick
  import rfs_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         restart_i,
  input  wire logic [W-1:0] period_i,
  // pulse
  output logic              tick_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] last;

  // a zero period behaves as one, so the pulse is high on every cycle
  assign last = (period_i == '0) ? '0 : period_i - W'(1);

  // free-running divider, cleared while restart is held
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q >= last) begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + W'(1);
      tick_o <= 1'b0;
    end
  end

endmodule

// ### rtl/rfs_top.sv
`timescale 1ns/10ps
module rfs_top
  import rfs_pkg::*;
#(
  parameter logic [31:0] MINUTE_CYCLES = 32'(MINUTE_CYC)
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic [31:0]            dat_o,
  output logic                   ack_o,
  // contact inputs
  input  wire logic              raise_input_i,
  input  wire logic              lower_input_i,
  input  wire logic              clear_input_i,
  input  wire logic              forward_start_input_i,
  input  wire logic              reverse_start_input_i,
  input  wire logic              second_ramp_select_i,
  // operating context
  input  wire logic              panel_mode_i,
  input  wire logic              ext_use_panel_i,
  input  wire logic              network_mode_i,
  input  wire logic              jog_active_i,
  input  wire logic              process_loop_active_i,
  input  wire logic [FREQ_W-1:0] ext_freq_i,
  input  wire logic [FREQ_W-1:0] analog_comp_i,
  // nonvolatile store
  input  wire logic              nvm_load_i,
  input  wire logic [FREQ_W-1:0] nvm_data_i,
  output logic                   nvm_wr_o,
  output logic [FREQ_W-1:0]      nvm_data_o,
  // results
  output logic [FREQ_W:0]        freq_cmd_o,
  output logic                   multispeed_en_o,
  output logic                   remote_active_o
);

  // ----------------------------------------------------------------
  // registers and bus slave
  // ----------------------------------------------------------------
  rfs_ctrl_t         ctrl_q;
  logic [FREQ_W-1:0] maxf_q;
  logic [FREQ_W-1:0] panel_q;
  rfs_ramp_t         prim_q;
  rfs_ramp_t         sec_q;
  logic [FREQ_W-1:0] remote_q;
  logic [FREQ_W-1:0] remote_d;
  logic [FREQ_W-1:0] chk_q;
  logic              armed_q;
  logic              raise_q;
  logic              lower_q;
  logic              start_q;
  logic              req;
  logic              wr;
  logic [31:0]       rd_d;
  logic [31:0]       wmask;

  assign req = cyc_i && stb_i && !ack_o;
  assign wr  = req && we_i;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // one-cycle acknowledge; unmapped addresses answer zero and drop writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= req;
      dat_o <= req ? rd_d : '0;
    end
  end

  // read mux
  always_comb begin
    rd_d = '0;
    if (adr_i == OFS_CTRL) begin
      rd_d = 32'(ctrl_q);
    end else if (adr_i == OFS_MAXF) begin
      rd_d = 32'(maxf_q);
    end else if (adr_i == OFS_PANEL) begin
      rd_d = 32'(panel_q);
    end else if (adr_i == OFS_PRIM) begin
      rd_d = prim_q;
    end else if (adr_i == OFS_SEC) begin
      rd_d = sec_q;
    end else if (adr_i == OFS_STAT) begin
      rd_d = {15'h0000, remote_active_o, remote_q};
    end else if (adr_i == OFS_CMD) begin
      rd_d = 32'(freq_cmd_o);
    end
  end

  // writable registers, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q  <= CTRL_RST;
      maxf_q  <= MAXF_RST;
      panel_q <= PANEL_RST;
      prim_q  <= PRIM_RST;
      sec_q   <= SEC_RST;
    end else if (wr) begin
      if (adr_i == OFS_CTRL) begin
        ctrl_q <= 3'((32'(ctrl_q) & ~wmask) | (dat_i & wmask));
      end else if (adr_i == OFS_MAXF) begin
        maxf_q <= 16'((32'(maxf_q) & ~wmask) | (dat_i & wmask));
      end else if (adr_i == OFS_PANEL) begin
        panel_q <= 16'((32'(panel_q) & ~wmask) | (dat_i & wmask));
      end else if (adr_i == OFS_PRIM) begin
        prim_q <= (prim_q & ~wmask) | (dat_i & wmask);
      end else if (adr_i == OFS_SEC) begin
        sec_q <= (sec_q & ~wmask) | (dat_i & wmask);
      end
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic remote_en;
  logic store_en;
  logic up;
  logic down;
  logic start;
  logic start_fall;
  logic rl_change;

  // network mode deliberately does not gate the function
  assign remote_en  = (ctrl_q.sel != SEL_MULTI)
                   && !jog_active_i && !process_loop_active_i;
  assign store_en   = (ctrl_q.sel == SEL_STORE);
  // exactly one of raise/lower ramps; both or neither holds
  assign up         = raise_input_i && !lower_input_i;
  assign down       = lower_input_i && !raise_input_i;
  assign start      = forward_start_input_i || reverse_start_input_i;
  assign start_fall = start_q && !start;
  assign rl_change  = (raise_q != raise_input_i) || (lower_q != lower_input_i);

  // mode flags to the rest of the drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      multispeed_en_o <= 1'b1;
      remote_active_o <= 1'b0;
    end else begin
      multispeed_en_o <= (ctrl_q.sel == SEL_MULTI);
      remote_active_o <= remote_en;
    end
  end

  // edge history of the contacts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raise_q <= 1'b0;
      lower_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      raise_q <= raise_input_i;
      lower_q <= lower_input_i;
      start_q <= start;
    end
  end

  // ----------------------------------------------------------------
  // ramp rate selection
  // ----------------------------------------------------------------
  logic [TIME_W-1:0] sec_dec;
  logic [TIME_W-1:0] up_per;
  logic [TIME_W-1:0] dn_per;
  logic              ramp_tick;

  // the second decel code for "same as accel" falls back to accel
  assign sec_dec = (sec_q.decel == DECEL_SAME) ? sec_q.accel : sec_q.decel;

  // rt off: the slower of second and primary times; rt on: second only
  always_comb begin
    if (second_ramp_select_i) begin
      up_per = sec_q.accel;
      dn_per = sec_dec;
    end else begin
      up_per = (prim_q.accel > sec_q.accel) ? prim_q.accel : sec_q.accel;
      dn_per = (prim_q.decel > sec_dec) ? prim_q.decel : sec_dec;
    end
  end

  rfs_tick #(
    .W (TIME_W)
  ) u_ramp (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .restart_i (!remote_en || !(up || down)),
    .period_i  (up ? up_per : dn_per),
    .tick_o    (ramp_tick)
  );

  // ----------------------------------------------------------------
  // remotely-set frequency
  // ----------------------------------------------------------------
  // priority: restore, clear, stop-clear, ramp; clamp to 0..max
  always_comb begin
    remote_d = remote_q;
    if (nvm_load_i && store_en) begin
      remote_d = nvm_data_i;
    end else if (remote_en && clear_input_i) begin
      remote_d = '0;
    end else if (remote_en && start_fall && ctrl_q.sel == SEL_STOPCLR) begin
      remote_d = '0;
    end else if (remote_en && ramp_tick) begin
      // ramps with or without a start command
      if (up && remote_q < maxf_q) begin
        remote_d = remote_q + FREQ_W'(1);
      end else if (down && remote_q != '0) begin
        remote_d = remote_q - FREQ_W'(1);
      end
    end
    if (remote_d > maxf_q) begin
      remote_d = maxf_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remote_q <= '0;
    end else begin
      remote_q <= remote_d;
    end
  end

  // ----------------------------------------------------------------
  // storage: on stop and on minute checks
  // ----------------------------------------------------------------
  logic minute_tick;
  logic chk_write;

  // each raise/lower change restarts the minute, so the first check
  // lands one minute after the last change, then once a minute
  rfs_tick #(
    .W (32)
  ) u_minute (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .restart_i (rl_change || !armed_q || !store_en),
    .period_i  (MINUTE_CYCLES),
    .tick_o    (minute_tick)
  );

  // the clear input plays no part in the write decision
  assign chk_write = minute_tick && (remote_q != chk_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
      chk_q   <= '0;
    end else begin
      if (rl_change && store_en) begin
        armed_q <= 1'b1;
      end else if (!store_en) begin
        armed_q <= 1'b0;
      end
      if (nvm_load_i && store_en) begin
        chk_q <= nvm_data_i;
      end else if (minute_tick) begin
        chk_q <= remote_q;
      end
    end
  end

  // write strobe; frequent use wears the store, which software avoids
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nvm_wr_o   <= 1'b0;
      nvm_data_o <= '0;
    end else begin
      nvm_wr_o   <= store_en && (start_fall || chk_write);
      nvm_data_o <= remote_q;
    end
  end

  // ----------------------------------------------------------------
  // output frequency command
  // ----------------------------------------------------------------
  logic [FREQ_W-1:0]   base;
  logic signed [17:0]  sum;
  logic [FREQ_W:0]     cap;
  logic [FREQ_W:0]     cmd_d;
  logic signed [17:0]  comp_x;

  // panel mode uses the panel frequency; external picks its source
  assign base   = (panel_mode_i || ext_use_panel_i) ? panel_q : ext_freq_i;
  // compensation only with the selector set; off means aux ignored
  assign comp_x = ctrl_q.comp ? 18'(signed'(analog_comp_i)) : '0;
  assign sum    = signed'(18'(base)) + signed'(18'(remote_en ? remote_q : '0))
                + comp_x;
  assign cap    = 17'(base) + 17'(maxf_q);

  always_comb begin
    if (sum < 0) begin
      cmd_d = '0;
    end else if (sum > signed'(18'(cap))) begin
      cmd_d = cap;
    end else begin
      cmd_d = 17'(sum);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_cmd_o <= '0;
    end else begin
      freq_cmd_o <= cmd_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  remote_range_a: assert property (1 |=> remote_q <= $past(maxf_q))
    else $error("remote frequency above maximum");
  total_cap_a: assert property (1 |=> freq_cmd_o <= $past(cap))
    else $error("command above main plus maximum");
  clear_zero_a: assert property (remote_en && clear_input_i && !nvm_load_i
    |=> remote_q == '0)
    else $error("clear did not zero remote frequency");
  stop_clear_a: assert property (remote_en && start_fall && ctrl_q.sel == SEL_STOPCLR
    && !nvm_load_i |=> remote_q == '0)
    else $error("stop did not clear remote frequency");
  hold_both_a: assert property (remote_en && !up && !down && !clear_input_i
    && !start_fall && !nvm_load_i && $stable(maxf_q) |=> $stable(remote_q))
    else $error("remote frequency moved without a ramp");
  stop_save_a: assert property (store_en && start_fall
    |=> nvm_wr_o && nvm_data_o == $past(remote_q))
    else $error("stop did not save the frequency");
  no_store_a: assert property (!store_en |=> !nvm_wr_o)
    else $error("store written in non-storing mode");
  multi_off_a: assert property (ctrl_q.sel != SEL_MULTI |=> !multispeed_en_o)
    else $error("multi-speed left enabled");
  jog_block_a: assert property (jog_active_i || process_loop_active_i
    |=> !remote_active_o)
    else $error("remote function active during jog or loop");
  ramp_slow_a: assert property (!second_ramp_select_i
    |-> up_per >= sec_q.accel && up_per >= prim_q.accel)
    else $error("ramp period not the longer time");

endmodule

// ### tb/rfs_contacts.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// contact switches on the far side
// ----------------------------------------------------------------
module rfs_contacts (
  // clock
  input  wire logic clk_i,
  // contacts, high means closed
  output logic      raise_o,
  output logic      lower_o,
  output logic      clear_o,
  output logic      fwd_o,
  output logic      rev_o,
  output logic      rt_o
);
  // all contacts open at power-up
  initial begin
    {rt_o, rev_o, fwd_o, clear_o, lower_o, raise_o} = 6'h00;
  end

  // contacts move right after an edge so the drive samples a settled level
  task automatic drive(input logic [5:0] v);
    @(posedge clk_i);
    {rt_o, rev_o, fwd_o, clear_o, lower_o, raise_o} <= v;
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import rfs_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, nvm_load_i = 1'b0;
  logic [7:0]        adr_i = 8'h00;
  logic [31:0]       dat_i = 32'h0, dat_o, rd;
  logic              ack_o, nvm_wr_o, multispeed_en_o, remote_active_o;
  logic              raise, lower, clear, fwd, rev, rt;
  logic              panel_mode_i = 1'b0, ext_use_panel_i = 1'b0, network_mode_i = 1'b0;
  logic              jog_active_i = 1'b0, process_loop_active_i = 1'b0;
  logic [FREQ_W-1:0] ext_freq_i = 16'h0200, analog_comp_i = 16'h0000;
  // wr_val doubles as the store model: it holds the last value written
  logic [FREQ_W-1:0] nvm_data_o, wr_val = 16'h0000, keep;
  logic [FREQ_W:0]   freq_cmd_o;
  int                failures = 0, tests_run = 0, cycles = 0, wr_cnt = 0, n0;

  // 25 ns period, short minute so periodic saves fit the run
  always #12.5 clk_i = ~clk_i;

  rfs_top #(.MINUTE_CYCLES(32'd50)) rfs_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .raise_input_i(raise), .lower_input_i(lower), .clear_input_i(clear),
    .forward_start_input_i(fwd), .reverse_start_input_i(rev),
    .second_ramp_select_i(rt), .panel_mode_i(panel_mode_i),
    .ext_use_panel_i(ext_use_panel_i), .network_mode_i(network_mode_i),
    .jog_active_i(jog_active_i), .process_loop_active_i(process_loop_active_i),
    .ext_freq_i(ext_freq_i), .analog_comp_i(analog_comp_i), .nvm_load_i(nvm_load_i),
    .nvm_data_i(wr_val), .nvm_wr_o(nvm_wr_o), .nvm_data_o(nvm_data_o),
    .freq_cmd_o(freq_cmd_o), .multispeed_en_o(multispeed_en_o),
    .remote_active_o(remote_active_o));

  rfs_contacts rfs_contacts_i (
    .clk_i(clk_i), .raise_o(raise), .lower_o(lower), .clear_o(clear),
    .fwd_o(fwd), .rev_o(rev), .rt_o(rt));

  // ----------------------------------------------------------------
  // store write monitor and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (nvm_wr_o === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_val <= nvm_data_o;
    end
  end

  // whole run is about 1,100 cycles, so this only trips on a hang
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // ramp step timing is only known to within one step, so allow a band
  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi, input string m);
    tests_run++;
    if ($isunknown(got) || got < lo || got > hi) begin
      failures++;
      $display("unexpected at %0t: %s got %0d want %0d..%0d", $time, m, got, lo, hi);
    end
  endtask

  // single classic cycle; held until ack is seen high at an edge
  // a lost ack is left to the hang guard, which fails the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  // hold a contact pattern, release, then read the remote frequency
  task automatic ramp(input logic [5:0] v, input int n, input int lo, input int hi);
    rfs_contacts_i.drive(v);
    repeat (n) @(posedge clk_i);
    rfs_contacts_i.drive(6'h00);
    repeat (4) @(posedge clk_i);
    wb(1'b0, OFS_STAT, 32'h0);
    chk_rng(rd[15:0], lo, hi, "remote");
  endtask

  // ----------------------------------------------------------------
  // sequence; contact bits are {rt, rev, fwd, clear, lower, raise}
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OFS_CTRL, 32'h0); chk(rd, 32'h0, "ctrl");
    wb(1'b0, OFS_MAXF, 32'h0); chk(rd, 32'h00002ee0, "maxf");
    wb(1'b0, OFS_PRIM, 32'h0); chk(rd, 32'h82358235, "prim");
    wb(1'b0, OFS_SEC, 32'h0);  chk(rd, 32'h270f8235, "sec");
    wb(1'b0, 8'h1c, 32'h0);    chk(rd, 32'h0, "unmapped");
    chk({31'h0, multispeed_en_o}, 32'h1, "multi on");
    wb(1'b1, OFS_CTRL, 32'h2);
    wb(1'b1, OFS_MAXF, 32'h10);
    wb(1'b1, OFS_PRIM, 32'h00080008);
    wb(1'b1, OFS_SEC, 32'h00020002);
    wb(1'b1, OFS_PANEL, 32'h100);
    wb(1'b1, OFS_STAT, 32'hffff);
    chk({30'h0, multispeed_en_o, remote_active_o}, 32'h1, "modes");
    ramp(6'h21, 60, 16, 16);
    ramp(6'h23, 30, 16, 16);
    ramp(6'h22, 10, 10, 12);
    ramp(6'h21, 60, 16, 16);
    ramp(6'h02, 40, 10, 12);
    ramp(6'h04, 3, 0, 0);
    ramp(6'h21, 60, 16, 16);
    // output command for each operating place and compensation
    panel_mode_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({15'h0, freq_cmd_o}, 32'h110, "panel");
    panel_mode_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({15'h0, freq_cmd_o}, 32'h210, "external");
    ext_use_panel_i <= 1'b1;
    analog_comp_i <= 16'hfffb;
    repeat (4) @(posedge clk_i);
    chk({15'h0, freq_cmd_o}, 32'h110, "ext panel");
    wb(1'b1, OFS_CTRL, 32'h6);
    repeat (4) @(posedge clk_i);
    chk({15'h0, freq_cmd_o}, 32'h10b, "comp");
    analog_comp_i <= 16'h0005;
    repeat (4) @(posedge clk_i);
    chk({15'h0, freq_cmd_o}, 32'h110, "cap");
    wb(1'b1, OFS_CTRL, 32'h2);
    // jog and process loop lock the remote value
    jog_active_i <= 1'b1;
    ramp(6'h22, 20, 16, 16);
    chk({31'h0, remote_active_o}, 32'h0, "jog");
    jog_active_i <= 1'b0;
    process_loop_active_i <= 1'b1;
    ramp(6'h24, 3, 16, 16);
    process_loop_active_i <= 1'b0;
    network_mode_i <= 1'b1;
    ramp(6'h04, 3, 0, 0);
    ramp(6'h21, 60, 16, 16);
    chk(wr_cnt, 32'h0, "no store");
    // storing mode: stop save, then periodic saves
    wb(1'b1, OFS_CTRL, 32'h1);
    repeat (200) @(posedge clk_i);
    n0 = wr_cnt;
    rfs_contacts_i.drive(6'h08);
    rfs_contacts_i.drive(6'h00);
    repeat (4) @(posedge clk_i);
    chk(wr_cnt - n0, 32'h1, "stop save");
    chk({16'h0, wr_val}, 32'h10, "stop val");
    n0 = wr_cnt;
    ramp(6'h22, 4, 13, 15);
    keep = rd[15:0];
    repeat (30) @(posedge clk_i);
    chk(wr_cnt - n0, 32'h0, "early");
    repeat (25) @(posedge clk_i);
    chk(wr_cnt - n0, 32'h1, "minute");
    chk({16'h0, wr_val}, {16'h0, keep}, "minute val");
    repeat (110) @(posedge clk_i);
    chk(wr_cnt - n0, 32'h1, "unchanged");
    ramp(6'h04, 3, 0, 0);
    repeat (60) @(posedge clk_i);
    chk(wr_cnt - n0, 32'h2, "clear save");
    chk({16'h0, wr_val}, 32'h0, "clear val");
    // power-up restore after the minute: the cleared value comes back
    @(posedge clk_i);
    nvm_load_i <= 1'b1;
    @(posedge clk_i);
    nvm_load_i <= 1'b0;
    ramp(6'h00, 1, 0, 0);
    // save on stop, clear within the minute, restore the earlier value
    ramp(6'h21, 60, 16, 16);
    rfs_contacts_i.drive(6'h08);
    rfs_contacts_i.drive(6'h00);
    repeat (4) @(posedge clk_i);
    chk({16'h0, wr_val}, 32'h10, "stop val 2");
    ramp(6'h04, 3, 0, 0);
    @(posedge clk_i);
    nvm_load_i <= 1'b1;
    @(posedge clk_i);
    nvm_load_i <= 1'b0;
    ramp(6'h00, 1, 16, 16);
    wb(1'b1, OFS_CTRL, 32'h3);
    n0 = wr_cnt;
    ramp(6'h22, 6, 12, 14);
    ramp(6'h08, 2, 0, 0);
    chk(wr_cnt - n0, 32'h0, "no store 3");
    test_done();
  end
endmodule
